// [core/gsr_regs.svh]
// Register offsets, field positions and reset values of the status group
`ifndef GSR_REGS_SVH
`define GSR_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_GLOBAL_STATUS   7'h01
`define ADDR_WRITE_COUNTER   7'h02
`define ADDR_REPLY_DELAY     7'h03
`define ADDR_FUSE_PROGRAM    7'h04
`define ADDR_FUSE_READ       7'h05
`define ADDR_INPUT_PIN       7'h06

// ----------------------------------------------------------------------
// Global status flag positions and reset value
// ----------------------------------------------------------------------
`define STAT_RESET_BIT       0
`define STAT_DRVERR_BIT      1
`define STAT_UV_BIT          2
`define STAT_RESET_VALUE     1'b1
`define STAT_CLEAR_VALUE     1'b0

// ----------------------------------------------------------------------
// Field positions, fuse key, widths and reset values
// ----------------------------------------------------------------------
`define DELAY_MSB            11
`define DELAY_LSB            8
`define DELAY_BITS_RESET     7'h08
`define FUSE_BIT_MSB         2
`define FUSE_BIT_LSB         0
`define FUSE_BYTE_MSB        5
`define FUSE_BYTE_LSB        4
`define FUSE_KEY_MSB         15
`define FUSE_KEY_LSB         8
`define FUSE_KEY_VALUE       8'hBD
`define FUSE_BYTE_BITS       8
`define FUSE_WIDTH           24
`define PIN_COUNT            4
`define VERSION_MSB          31
`define VERSION_LSB          24
`define COUNT_RESET          8'h00
`define COUNT_STEP           8'h01

`endif

// [core/gsr_pkg.sv]
// Types shared by the status register group
package gsr_pkg;

  typedef logic [6:0]  reg_addr_t;
  typedef logic [31:0] reg_data_t;
  typedef logic [23:0] fuse_word_t;
  typedef logic [6:0]  bit_times_t;

  // Read source picked by the address decoder
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_STATUS,
    SEL_COUNT,
    SEL_FUSE,
    SEL_PINS
  } read_sel_t;

endpackage

// [core/fuse_if.sv]
// Link between the register group and the fuse store
`timescale 1ns/1ps

interface fuse_if;
  logic              prog_req;
  logic [1:0]        byte_sel;
  logic [2:0]        bit_sel;
  gsr_pkg::fuse_word_t bits;

  modport ctrl  (output prog_req, output byte_sel, output bit_sel,
                 input bits);
  modport store (input prog_req, input byte_sel, input bit_sel,
                 output bits);
endinterface

// [core/fuse_array.sv]
// One-time programmable fuse store, 3 bytes, set-only
`timescale 1ns/1ps
`include "gsr_regs.svh"

module fuse_array (
  input wire logic clk,
  fuse_if.store    fif
);

  // ----------------------------------------------------------------------
  // Fuse cells
  // ----------------------------------------------------------------------
  // No reset on purpose: a reset must never erase a programmed fuse
  for (genvar i = 0; i < `FUSE_WIDTH; i++) begin : g_cell
    logic cell_q = 1'b0;
    wire  hit    = fif.prog_req
                   && (fif.byte_sel == 2'(i / `FUSE_BYTE_BITS))
                   && (fif.bit_sel == 3'(i % `FUSE_BYTE_BITS));
    always_ff @(posedge clk) begin
      if (hit) begin
        cell_q <= 1'b1;
      end
    end
    assign fif.bits[i] = cell_q;
  end

endmodule

// [core/driver_general_status_regs.sv]
// General status, write counter, reply delay, fuse and pin registers
`timescale 1ns/1ps
`include "gsr_regs.svh"

// Behaviour
// - Writing one to status flag bit 0 or 1 clears it; zero leaves it alone.
// - Reset flag bit 0 set by reset; reset restores all registers except the fuse cells.
// - Bit 1 set when power stage shuts down on overtemp or short.
// - Clearing bit 1 has no effect while any fault remains active.
// - Bit 2 follows pump undervoltage unlatched; power stage stays off.
// - Eight bit write counter at 0x02 counts each successful write.
// - Reading the write counter leaves it unchanged.
// - Write counter wraps from 255 to 0.
// - Delay field bits 11..8 at 0x03 selects odd multiples of 8 bits.
// - Keyed write at 0x04 programs one fuse bit chosen by bits 2..0.
// - Bits 5..4 choose fuse byte 0, 1 or 2.
// - Programming happens only when bits 15..8 carry key 0xBD.
// - A read after programming reloads fuse read data from the array.
// - Fuse data at 0x05: byte 0, 1, 2 in bits 7..0, 15..8, 23..16.
// - Pin register at 0x06 returns synchronised input pin levels.
// - Fuses start at zero and can only be set.
// - Bits 31..24 of pin register hold a fixed version code.

module driver_general_status_regs #(
  // Arbitrary value, neutral version code
  parameter logic [7:0] VERSION_CODE = 8'h5A
) (
  input  wire logic                SYS_CLK,
  input  wire logic                RSTN,
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  input  wire gsr_pkg::reg_addr_t  REG_ADDR,
  input  wire gsr_pkg::reg_data_t  REG_WDATA,
  output gsr_pkg::reg_data_t       REG_RDATA,
  output logic                     REG_RVALID,
  input  wire logic                OVERTEMP_ERR,
  input  wire logic                SHORT_ERR,
  input  wire logic                PUMP_UV,
  input  wire logic                ENABLE_N_PIN,
  input  wire logic                PDN_SERIAL_PIN,
  input  wire logic                MICROSTEP_SELECT_A,
  input  wire logic                MICROSTEP_SELECT_B,
  output logic [2:0]               STATUS_FLAGS,
  output logic [7:0]               WRITE_COUNT,
  output gsr_pkg::bit_times_t      REPLY_DELAY_BITS,
  output logic                     POWER_STAGE_OFF,
  output gsr_pkg::fuse_word_t      FUSE_DATA
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic                 reset_flag_q;
  logic                 drv_err_q;
  logic                 drv_err_d;
  logic                 pump_uv_q;
  logic                 power_off_q;
  logic [7:0]           count_q;
  gsr_pkg::bit_times_t  delay_bits_q;
  gsr_pkg::fuse_word_t  fuse_q;
  logic                 fuse_dirty_q;
  logic [`PIN_COUNT-1:0] pins_q;
  gsr_pkg::reg_data_t   rdata_q;
  logic                 rvalid_q;
  gsr_pkg::read_sel_t   read_sel;

  fuse_if fif ();

  fuse_array u_fuse (
    .clk (SYS_CLK),
    .fif (fif)
  );

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire hit_status = (REG_ADDR == `ADDR_GLOBAL_STATUS);
  wire hit_count  = (REG_ADDR == `ADDR_WRITE_COUNTER);
  wire hit_delay  = (REG_ADDR == `ADDR_REPLY_DELAY);
  wire hit_prog   = (REG_ADDR == `ADDR_FUSE_PROGRAM);
  wire hit_fuse   = (REG_ADDR == `ADDR_FUSE_READ);
  wire hit_pins   = (REG_ADDR == `ADDR_INPUT_PIN);

  // Write strobes only for writable registers; others fall through
  // Read-only targets get no strobe
  wire wr_status  = REG_WR && hit_status;
  wire wr_delay   = REG_WR && hit_delay;
  wire wr_prog    = REG_WR && hit_prog;

  // Read source selection, write-only registers read as zero
  always_comb begin
    if (hit_status) begin
      read_sel = gsr_pkg::SEL_STATUS;
    end else if (hit_count) begin
      read_sel = gsr_pkg::SEL_COUNT;
    end else if (hit_fuse) begin
      read_sel = gsr_pkg::SEL_FUSE;
    end else if (hit_pins) begin
      read_sel = gsr_pkg::SEL_PINS;
    end else begin
      read_sel = gsr_pkg::SEL_NONE;
    end
  end

  // ----------------------------------------------------------------------
  // Global status flags
  // ----------------------------------------------------------------------
  wire fault_active = OVERTEMP_ERR || SHORT_ERR;
  wire clr_reset    = wr_status && REG_WDATA[`STAT_RESET_BIT];
  wire clr_drv_err  = wr_status && REG_WDATA[`STAT_DRVERR_BIT];

  // Fault sets the flag and wins over a clear
  // Clear ignored while a fault lasts
  assign drv_err_d = fault_active ? 1'b1 :
                     (clr_drv_err ? `STAT_CLEAR_VALUE : drv_err_q);

  // Reset flag raised by reset, cleared by write one
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      reset_flag_q <= `STAT_RESET_VALUE;
    end else if (clr_reset) begin
      reset_flag_q <= `STAT_CLEAR_VALUE;
    end
  end

  // Write one to clear the driver fault flag
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      drv_err_q <= `STAT_CLEAR_VALUE;
    end else begin
      drv_err_q <= drv_err_d;
    end
  end

  // Undervoltage mirrored, no latch; power stage held off
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pump_uv_q   <= `STAT_CLEAR_VALUE;
      power_off_q <= 1'b1;
    end else begin
      pump_uv_q   <= PUMP_UV;
      power_off_q <= PUMP_UV || fault_active;
    end
  end

  // ----------------------------------------------------------------------
  // Interface write counter
  // ----------------------------------------------------------------------
  // Every accepted frame counts, even one aimed at a read-only register,
  // so the host can spot lost frames regardless of target
  // Count each write, wrapping naturally
  // Eight bit add wraps 255 to 0
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      count_q <= `COUNT_RESET;
    end else if (REG_WR) begin
      count_q <= count_q + `COUNT_STEP;
    end
  end

  // ----------------------------------------------------------------------
  // Reply delay
  // ----------------------------------------------------------------------
  // Field pairs 2k, 2k+1 share (2k+1)*8 bit times: force lsb, times 8
  wire [3:0]           delay_field = REG_WDATA[`DELAY_MSB:`DELAY_LSB];
  gsr_pkg::bit_times_t delay_calc;
  assign delay_calc = {delay_field[3:1], 1'b1, 3'b000};

  // Keep only the bit time count; the raw field is never read
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      delay_bits_q <= `DELAY_BITS_RESET;
    end else if (wr_delay) begin
      delay_bits_q <= delay_calc;
    end
  end

  // ----------------------------------------------------------------------
  // Fuse programming and read-back
  // ----------------------------------------------------------------------
  // Key must match before anything is programmed
  wire key_ok  = (REG_WDATA[`FUSE_KEY_MSB:`FUSE_KEY_LSB] == `FUSE_KEY_VALUE);
  wire prog_ok = wr_prog && key_ok;

  // Byte select 3 matches no cell and is dropped
  assign fif.prog_req = prog_ok;
  assign fif.bit_sel  = REG_WDATA[`FUSE_BIT_MSB:`FUSE_BIT_LSB];
  assign fif.byte_sel = REG_WDATA[`FUSE_BYTE_MSB:`FUSE_BYTE_LSB];

  // Snapshot served to reads; dirty after reset so first read loads it
  wire                 reload   = REG_RD && fuse_dirty_q;
  gsr_pkg::fuse_word_t fuse_rd;
  assign fuse_rd = fuse_dirty_q ? fif.bits : fuse_q;

  // Any read after programming refreshes the snapshot
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      fuse_q       <= '0;
      fuse_dirty_q <= 1'b1;
    end else if (prog_ok) begin
      fuse_dirty_q <= 1'b1;
    end else if (reload) begin
      fuse_q       <= fif.bits;
      fuse_dirty_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Input pin synchronisers
  // ----------------------------------------------------------------------
  wire [`PIN_COUNT-1:0] pins_raw = {MICROSTEP_SELECT_B, MICROSTEP_SELECT_A,
                                    PDN_SERIAL_PIN, ENABLE_N_PIN};

  // Three stages; a level is taken only once stages two and three agree
  for (genvar p = 0; p < `PIN_COUNT; p++) begin : g_pin
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
      end else begin
        s1_q <= pins_raw[p];
        s2_q <= s1_q;
        s3_q <= s2_q;
      end
    end
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
        pins_q[p] <= 1'b0;
      end else if (s2_q == s3_q) begin
        pins_q[p] <= s3_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  wire [2:0] status_word = {pump_uv_q, drv_err_q, reset_flag_q};
  gsr_pkg::reg_data_t rd_mux;

  // Fuse bytes packed low to high
  // Version code in the top byte of the pin register
  assign rd_mux =
    (read_sel == gsr_pkg::SEL_STATUS) ? {29'h0, status_word} :
    (read_sel == gsr_pkg::SEL_COUNT)  ? {24'h0, count_q} :
    (read_sel == gsr_pkg::SEL_FUSE)   ? {8'h00, fuse_rd} :
    (read_sel == gsr_pkg::SEL_PINS)   ? {VERSION_CODE, 20'h0, pins_q} :
                                        32'h0;

  // Reads capture data; apart from the fuse snapshot reload, no register is touched
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= REG_RD;
      if (REG_RD) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign REG_RDATA        = rdata_q;
  assign REG_RVALID       = rvalid_q;
  assign STATUS_FLAGS     = status_word;
  assign WRITE_COUNT      = count_q;
  assign REPLY_DELAY_BITS = delay_bits_q;
  assign POWER_STAGE_OFF  = power_off_q;
  assign FUSE_DATA        = fuse_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  sequence s_prog_write;
    prog_ok;
  endsequence

  sequence s_read_after;
    ##1 REG_RD;
  endsequence

  property p_status_clear;
    clr_reset |=> !reset_flag_q;
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("reset flag not cleared by write one");

  property p_reset_stays_clear;
    !reset_flag_q |=> !reset_flag_q;
  endproperty
  a_reset_stays_clear: assert property (p_reset_stays_clear)
    else $error("reset flag rose without reset");

  property p_fault_sets;
    fault_active |=> drv_err_q && STATUS_FLAGS[`STAT_DRVERR_BIT];
  endproperty
  a_fault_sets: assert property (p_fault_sets)
    else $error("driver fault flag not set by fault");

  property p_fault_blocks_clear;
    $fell(drv_err_q) |-> $past(clr_drv_err) && !$past(fault_active);
  endproperty
  a_fault_blocks_clear: assert property (p_fault_blocks_clear)
    else $error("driver fault flag cleared while fault active");

  property p_uv_follow;
    PUMP_UV |=> STATUS_FLAGS[`STAT_UV_BIT] && POWER_STAGE_OFF;
  endproperty
  a_uv_follow: assert property (p_uv_follow)
    else $error("undervoltage not mirrored or power stage on");

  property p_count_step;
    REG_WR |=> count_q == $past(count_q) + `COUNT_STEP;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("write counter did not advance by one");

  property p_count_idle;
    !REG_WR |=> $stable(count_q);
  endproperty
  a_count_idle: assert property (p_count_idle)
    else $error("write counter changed without a write");

  property p_count_wrap;
    REG_WR && (count_q == 8'hFF) |=> count_q == `COUNT_RESET;
  endproperty
  a_count_wrap: assert property (p_count_wrap)
    else $error("write counter did not wrap to zero");

  property p_delay;
    wr_delay |=> REPLY_DELAY_BITS == 7'(($past(delay_field) | 4'h1) * 8);
  endproperty
  a_delay: assert property (p_delay)
    else $error("reply delay bit times wrong");

  property p_fuse_bit;
    (s_prog_write and (fif.byte_sel != 2'h3)) |=>
      fif.bits[{$past(fif.byte_sel), $past(fif.bit_sel)}];
  endproperty
  a_fuse_bit: assert property (p_fuse_bit)
    else $error("selected fuse bit not programmed");

  property p_fuse_key;
    wr_prog && !key_ok |=> $stable(fif.bits);
  endproperty
  a_fuse_key: assert property (p_fuse_key)
    else $error("fuse changed without key");

  property p_fuse_reload;
    s_prog_write ##0 s_read_after |=> fuse_q == $past(fif.bits);
  endproperty
  a_fuse_reload: assert property (p_fuse_reload)
    else $error("fuse snapshot not reloaded after programming");

  property p_fuse_read;
    REG_RD && hit_fuse |=> REG_RDATA == {8'h00, $past(fuse_rd)};
  endproperty
  a_fuse_read: assert property (p_fuse_read)
    else $error("fuse read data layout wrong");

  property p_pin_read;
    REG_RD && hit_pins |=> REG_RVALID
      && REG_RDATA[`PIN_COUNT-1:0] == $past(pins_q)
      && REG_RDATA[`VERSION_MSB:`VERSION_LSB] == VERSION_CODE;
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("pin register read wrong");

  property p_fuse_set_only;
    ($past(fif.bits) & ~fif.bits) == '0;
  endproperty
  a_fuse_set_only: assert property (p_fuse_set_only)
    else $error("programmed fuse bit returned to zero");

  property p_ro_write;
    REG_WR && !hit_delay |=> $stable(REPLY_DELAY_BITS) && $stable(fuse_q);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("stray write altered a setting");

endmodule

// [verification/host_model.sv]
// Host controller model driving the register port of the status group
`timescale 1ns/1ps
`include "gsr_regs.svh"

module host_model #(
  // Shortened programming wait, in clock cycles
  parameter int PROG_WAIT = 20
) (
  input  wire logic               clk,
  output logic                    wr,
  output logic                    rd,
  output gsr_pkg::reg_addr_t      addr,
  output gsr_pkg::reg_data_t      wdata,
  input  wire gsr_pkg::reg_data_t rdata,
  input  wire logic               rvalid
);
  // ----------------------------------------------------------------------
  // Bus idle state
  // ----------------------------------------------------------------------
  initial begin
    wr    = 1'b0;
    rd    = 1'b0;
    addr  = 7'h00;
    wdata = 32'h00000000;
  end

  // Released lines flip so stale values never look valid
  task automatic idle_bus();
    addr  = ~addr;
    wdata = ~wdata;
  endtask

  // One write pulse, taken at the next edge
  task automatic write(input gsr_pkg::reg_addr_t a,
                       input gsr_pkg::reg_data_t d);
    @(posedge clk);
    #1;
    wr    = 1'b1;
    addr  = a;
    wdata = d;
    @(posedge clk);
    #1;
    wr = 1'b0;
    idle_bus();
  endtask

  // One read pulse, then a bounded wait for the answer
  task automatic read(input gsr_pkg::reg_addr_t a,
                      output gsr_pkg::reg_data_t d, output logic ok);
    int n;
    @(posedge clk);
    #1;
    rd   = 1'b1;
    addr = a;
    @(posedge clk);
    #1;
    rd = 1'b0;
    idle_bus();
    n = 0;
    while (rvalid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    ok = (rvalid === 1'b1);
    d  = rdata;
  endtask

  // Keyed write, then a read on the very next edge
  task automatic program_then_read(input logic [1:0] byte_sel,
                                   input logic [2:0] bit_sel,
                                   output gsr_pkg::reg_data_t d,
                                   output logic ok);
    @(posedge clk);
    #1;
    wr    = 1'b1;
    addr  = `ADDR_FUSE_PROGRAM;
    wdata = {16'h0000, `FUSE_KEY_VALUE, 2'b00, byte_sel, 1'b0, bit_sel};
    @(posedge clk);
    #1;
    wr   = 1'b0;
    rd   = 1'b1;
    addr = `ADDR_FUSE_READ;
    @(posedge clk);
    #1;
    rd = 1'b0;
    idle_bus();
    ok = (rvalid === 1'b1);
    d  = rdata;
  endtask

  task automatic program_fuse(input logic [1:0] byte_sel,
                              input logic [2:0] bit_sel,
                              input logic [7:0] key);
    write(`ADDR_FUSE_PROGRAM,
          {16'h0000, key, 2'b00, byte_sel, 1'b0, bit_sel});
    repeat (PROG_WAIT) @(posedge clk);
  endtask
endmodule

// [verification/testbench.sv]
// Self-checking bench for the general status register group
`timescale 1ns/1ps
`include "gsr_regs.svh"

module testbench;
  // Arbitrary version code handed to the design
  localparam logic [7:0] VER   = 8'h3C;
  localparam int         LIMIT = 20000;

  typedef struct packed {
    logic [3:0]          field;
    gsr_pkg::bit_times_t bits;
  } delay_row_t;

  logic                SYS_CLK, RSTN, wr, rd, rvalid;
  logic                ot_err, sc_err, uv;
  logic [3:0]          pins;
  gsr_pkg::reg_addr_t  addr;
  gsr_pkg::reg_data_t  wdata, rdata;
  logic [2:0]          flags;
  logic [7:0]          count, exp_cnt;
  gsr_pkg::bit_times_t delay;
  logic                pwr_off;
  gsr_pkg::fuse_word_t fuse;
  gsr_pkg::reg_data_t  b2b_data;
  logic                b2b_ok;
  delay_row_t          rows [16];
  int                  failures, tests_run, cycles;

  driver_general_status_regs #(.VERSION_CODE(VER)) uut (
    .SYS_CLK(SYS_CLK), .RSTN(RSTN), .REG_WR(wr), .REG_RD(rd),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .REG_RVALID(rvalid), .OVERTEMP_ERR(ot_err), .SHORT_ERR(sc_err),
    .PUMP_UV(uv), .ENABLE_N_PIN(pins[0]), .PDN_SERIAL_PIN(pins[1]),
    .MICROSTEP_SELECT_A(pins[2]), .MICROSTEP_SELECT_B(pins[3]),
    .STATUS_FLAGS(flags), .WRITE_COUNT(count),
    .REPLY_DELAY_BITS(delay), .POWER_STAGE_OFF(pwr_off),
    .FUSE_DATA(fuse));

  host_model #(.PROG_WAIT(20)) host (
    .clk(SYS_CLK), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata),
    .rdata(rdata), .rvalid(rvalid));

  // ----------------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------------
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end

  initial cycles = 0;
  always @(posedge SYS_CLK) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check_port(input string name, input gsr_pkg::reg_data_t e,
                            input gsr_pkg::reg_data_t g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask

  // Reads go through the host; a missing answer counts as a mismatch
  task automatic check_read(input string name, input gsr_pkg::reg_addr_t a,
                            input gsr_pkg::reg_data_t e);
    gsr_pkg::reg_data_t d;
    logic               ok;
    host.read(a, d, ok);
    tests_run++;
    if (ok !== 1'b1 || d !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, e, d);
    end
  endtask

  // Writes take effect on the edge that takes them; one spare edge follows
  task automatic do_write(input gsr_pkg::reg_addr_t a,
                          input gsr_pkg::reg_data_t d);
    host.write(a, d);
    exp_cnt = exp_cnt + 8'h01;
    @(posedge SYS_CLK);
    #1;
  endtask

  task automatic do_prog(input logic [1:0] b, input logic [2:0] n,
                         input logic [7:0] key);
    host.program_fuse(b, n, key);
    exp_cnt = exp_cnt + 8'h01;
  endtask

  task automatic apply_reset();
    RSTN = 1'b0;
    repeat (6) @(posedge SYS_CLK);
    #1;
    RSTN    = 1'b1;
    exp_cnt = 8'h00;
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    failures = 0;
    tests_run = 0;
    {ot_err, sc_err, uv} = 3'b000;
    pins = 4'h0;
    for (int i = 0; i < 16; i++) begin
      rows[i] = '{field: 4'(i), bits: 7'(((i / 2) * 2 + 1) * 8)};
    end
    apply_reset();
    check_port("flags", 32'h1, {29'h0, flags});
    check_port("count", 32'h0, {24'h0, count});
    check_port("delay", 32'h8, {25'h0, delay});
    check_read("status", `ADDR_GLOBAL_STATUS, 32'h1);
    do_write(`ADDR_GLOBAL_STATUS, 32'h0);
    check_read("status", `ADDR_GLOBAL_STATUS, 32'h1);
    do_write(`ADDR_GLOBAL_STATUS, 32'h7);
    check_read("status", `ADDR_GLOBAL_STATUS, 32'h0);
    end_test("reset and clear");

    // Every delay code, odd and even
    foreach (rows[i]) begin
      do_write(`ADDR_REPLY_DELAY, {20'h0, rows[i].field, 8'h00});
      check_port("delay", {25'h0, rows[i].bits}, {25'h0, delay});
    end
    check_read("delay reg", `ADDR_REPLY_DELAY, 32'h0);
    check_port("delay", 32'h78, {25'h0, delay});
    end_test("reply delay");

    check_read("count", `ADDR_WRITE_COUNTER, {24'h0, exp_cnt});
    check_read("count", `ADDR_WRITE_COUNTER, {24'h0, exp_cnt});
    do_write(`ADDR_WRITE_COUNTER, 32'h000000F0);
    check_port("count", {24'h0, exp_cnt}, {24'h0, count});
    while (exp_cnt != 8'hFF) begin
      do_write(7'h7F, 32'h0);
    end
    check_port("count", 32'hFF, {24'h0, count});
    do_write(7'h7F, 32'h0);
    check_port("count", 32'h0, {24'h0, count});
    end_test("write counter");

    // Each fault source latches and resists clearing while active
    for (int k = 0; k < 2; k++) begin
      ot_err = (k == 0);
      sc_err = (k == 1);
      repeat (2) @(posedge SYS_CLK);
      #1;
      check_read("status", `ADDR_GLOBAL_STATUS, 32'h2);
      check_port("power off", 32'h1, {31'h0, pwr_off});
      do_write(`ADDR_GLOBAL_STATUS, 32'h2);
      check_read("status", `ADDR_GLOBAL_STATUS, 32'h2);
      {ot_err, sc_err} = 2'b00;
      repeat (2) @(posedge SYS_CLK);
      #1;
      check_read("status", `ADDR_GLOBAL_STATUS, 32'h2);
      do_write(`ADDR_GLOBAL_STATUS, 32'h2);
      check_read("status", `ADDR_GLOBAL_STATUS, 32'h0);
    end
    uv = 1'b1;
    repeat (2) @(posedge SYS_CLK);
    #1;
    check_read("status", `ADDR_GLOBAL_STATUS, 32'h4);
    check_port("power off", 32'h1, {31'h0, pwr_off});
    uv = 1'b0;
    repeat (2) @(posedge SYS_CLK);
    #1;
    check_read("status", `ADDR_GLOBAL_STATUS, 32'h0);
    check_port("power off", 32'h0, {31'h0, pwr_off});
    end_test("faults");

    do_prog(2'd1, 3'd3, 8'h42);
    check_read("fuse", `ADDR_FUSE_READ, 32'h0);
    do_prog(2'd1, 3'd3, 8'hBD);
    check_read("fuse", `ADDR_FUSE_READ, 32'h000800);
    do_prog(2'd2, 3'd7, 8'hBD);
    check_read("fuse", `ADDR_FUSE_READ, 32'h800800);
    do_prog(2'd0, 3'd0, 8'hBD);
    check_read("fuse", `ADDR_FUSE_READ, 32'h800801);
    do_prog(2'd3, 3'd1, 8'hBD);
    check_read("fuse", `ADDR_FUSE_READ, 32'h800801);
    check_port("fuse port", 32'h800801, {8'h0, fuse});
    do_write(`ADDR_FUSE_READ, 32'h00FFFFFF);
    check_read("fuse", `ADDR_FUSE_READ, 32'h800801);
    // Cell sets in one cycle, so a read on the next edge must see it
    host.program_then_read(2'd0, 3'd5, b2b_data, b2b_ok);
    check_port("fuse b2b ok", 32'h1, {31'h0, b2b_ok});
    check_port("fuse b2b", 32'h800821, b2b_data);
    check_read("prog reg", `ADDR_FUSE_PROGRAM, 32'h0);
    check_read("unmapped", 7'h7F, 32'h0);
    apply_reset();
    check_read("fuse", `ADDR_FUSE_READ, 32'h800821);
    check_read("status", `ADDR_GLOBAL_STATUS, 32'h1);
    check_read("count", `ADDR_WRITE_COUNTER, 32'h0);
    end_test("fuses and second reset");

    // Pins pass a 3-stage synchroniser before they show
    for (int p = 0; p < 2; p++) begin
      pins = (p == 0) ? 4'h5 : 4'hA;
      repeat (6) @(posedge SYS_CLK);
      #1;
      check_read("pins", `ADDR_INPUT_PIN,
                 {VER, 20'h0, pins});
    end
    end_test("input pins");
    finish_test();
  end
endmodule
